// ### bzs_pkg.sv
// bzs_pkg: constants, register map and types of the buzzer one-shot / melody sequencer
package bzs_pkg;

    // ==========================================================
    // clock and sound clock
    // ==========================================================
    localparam int unsigned BZS_CLK_PERIOD_NS = 20;
    localparam int unsigned BZS_CLK_HZ = 1000000000 / BZS_CLK_PERIOD_NS;
    localparam int unsigned BZS_SOUND_CLK_HZ = 32768;
    // rounded to nearest, 1526 cycles per sound clock tick
    localparam int unsigned BZS_SND_DIV_CYC =
        (BZS_CLK_HZ + BZS_SOUND_CLK_HZ / 2) / BZS_SOUND_CLK_HZ;

    // ==========================================================
    // timing in sound clock ticks
    // ==========================================================
    // one-shot duration = base + step * code, about 5.9 ms .. 240 ms
    localparam int unsigned BZS_DUR_BASE_TICKS = 193;
    localparam int unsigned BZS_DUR_STEP_TICKS = 512;
    // thirty-second note at tempo code 0, scaled by code + 1
    localparam int unsigned BZS_UNIT_BASE_TICKS = 512;
    // silent gap at the start of an untied note
    localparam int unsigned BZS_BREAK_TICKS = 16;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [7:0] BZS_OFF_SELECT = 8'h00;
    localparam logic [7:0] BZS_OFF_BUFFER = 8'h04;
    localparam logic [7:0] BZS_OFF_FLAGS = 8'h08;

    // select register fields
    localparam int unsigned BZS_SEL_MODE_LSB = 0;
    localparam int unsigned BZS_SEL_DUR_LSB = 8;
    localparam logic [1:0] BZS_MODE_RST = 2'h0;
    localparam logic [3:0] BZS_DUR_RST = 4'h0;

    // flag register bits
    localparam int unsigned BZS_FLG_EMPTY = 0;
    localparam int unsigned BZS_FLG_BUSY = 1;
    localparam int unsigned BZS_FLG_DONE = 2;

    // output modes
    localparam logic [1:0] BZS_MODE_NORMAL = 2'h0;
    localparam logic [1:0] BZS_MODE_ONESHOT = 2'h1;
    localparam logic [1:0] BZS_MODE_MELODY = 2'h2;

    // sound buffer depth
    localparam int unsigned BZS_FIFO_DEPTH = 8;
    localparam int unsigned BZS_WORD_W = 16;

    // ==========================================================
    // types
    // ==========================================================
    // note word as written to the sound buffer, bits 15..0
    typedef struct packed {
        logic tie_bit;
        logic note_rest_bit;
        logic [5:0] length_field;
        logic [7:0] frequency_field;
    } bzs_word_t;

    typedef struct packed {
        logic [3:0] duration_tempo_field;
        logic [1:0] output_mode_field;
    } bzs_select_t;

    typedef enum logic [1:0] {
        BZS_IDLE = 2'b00,
        BZS_LOAD = 2'b01,
        BZS_PLAY = 2'b11
    } bzs_state_t;

endpackage

// ### bzs_fifo.sv
// bzs_fifo: small first-in first-out store with registered read data
`timescale 1ns/1ns
module bzs_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic pop_mem;

    // ==========================================================
    // handshakes
    // ==========================================================
    assign in_ready = (count_q != (AW + 1)'(DEPTH));
    assign push = in_valid & in_ready;
    // refill the output register whenever it is empty or being taken
    assign pop_mem = (count_q != '0) & (~out_valid_q | out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // ==========================================================
    // storage
    // ==========================================================
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= ptr_next(wptr_q);
            end
            if (pop_mem) begin
                rptr_q <= ptr_next(rptr_q);
            end
            if (push && !pop_mem) begin
                count_q <= count_q + 1'b1;
            end else if (!push && pop_mem) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (pop_mem) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rptr_q];
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

endmodule

// ### bzs_sequencer.sv
// bzs_sequencer: wishbone sound generator, one-shot buzzer and melody sequencer
//
// Behaviour
// - one-shot mode is output mode 1, with duration code set before buffer write.
// - melody mode is output mode 2, with tempo code set before first note.
// - a buffer write clears the empty flag and starts output in current mode.
// - one-shot load on sound clock sets empty and busy flags together.
// - one-shot tone: duty from length field, period from frequency field.
// - one-shot stops itself after duration; sets done, clears busy.
// - melody loads next word at note boundary, sets empty and busy, plays it.
// - melody with no new word at boundary ends output, sets done, clears busy.
// - note/rest bit 0 sounds a note, 1 gives silence, for the length given.
// - length codes 0,1,3,5,7,b,f give thirty-second up to half notes only.
// - tied note continues previous note with no break; same pitch required.
// - frequency code picks pitch; larger code means lower pitch.
// - done flag clears by writing one or writing buffer; no interrupt here.
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
module bzs_sequencer
    import bzs_pkg::*;
#(
    parameter int unsigned SND_DIV = BZS_SND_DIV_CYC,
    parameter int unsigned DUR_BASE = BZS_DUR_BASE_TICKS,
    parameter int unsigned DUR_STEP = BZS_DUR_STEP_TICKS,
    parameter int unsigned UNIT_BASE = BZS_UNIT_BASE_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic buzzer_o
);

    // ==========================================================
    // declarations
    // ==========================================================
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic buzzer_q;
    bzs_select_t sound_select_q;
    logic buffer_empty_q;
    logic output_busy_q;
    logic output_done_q;
    bzs_state_t state_q;
    bzs_word_t sound_reg_q;
    logic [10:0] div_q;
    logic tick_q;
    logic [7:0] tone_q;
    logic [13:0] sub_q;
    logic [5:0] units_q;

    logic req;
    logic wr_sel;
    logic wr_flags;
    logic push_want;
    logic ack_d;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    bzs_word_t fifo_out_word;
    logic [BZS_WORD_W-1:0] fifo_out_data;
    logic mode_ok;
    logic melody;
    logic load_now;
    logic end_now;
    logic next_note;
    logic finish;
    logic [13:0] unit_lim;
    logic [13:0] dur_lim;
    logic tone_high;
    logic mute;
    logic buzzer_d;
    logic [31:0] rd_data;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // ==========================================================
    // wishbone slave
    // ==========================================================
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    assign wr_sel = req & wb_we_i & hit(wb_adr_i, BZS_OFF_SELECT);
    assign wr_flags = req & wb_we_i & hit(wb_adr_i, BZS_OFF_FLAGS) & wb_sel_i[0];
    // a note word needs both low lanes; partial writes are acked and dropped
    assign push_want = req & wb_we_i & hit(wb_adr_i, BZS_OFF_BUFFER)
        & wb_sel_i[0] & wb_sel_i[1];
    // full buffer stalls the ack, so the master waits instead of losing notes
    assign ack_d = req & (~push_want | fifo_in_ready);

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(wb_adr_i, BZS_OFF_SELECT)) begin
            rd_data[BZS_SEL_DUR_LSB +: 4] = sound_select_q.duration_tempo_field;
            rd_data[BZS_SEL_MODE_LSB +: 2] = sound_select_q.output_mode_field;
        end else if (hit(wb_adr_i, BZS_OFF_BUFFER)) begin
            rd_data[BZS_WORD_W-1:0] = sound_reg_q;
        end else if (hit(wb_adr_i, BZS_OFF_FLAGS)) begin
            rd_data[BZS_FLG_EMPTY] = buffer_empty_q;
            rd_data[BZS_FLG_BUSY] = output_busy_q;
            rd_data[BZS_FLG_DONE] = output_done_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= ack_d;
            if (ack_d && !wb_we_i) begin
                wb_dat_q <= rd_data;
            end
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // ==========================================================
    // select register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sound_select_q.output_mode_field <= BZS_MODE_RST;
            sound_select_q.duration_tempo_field <= BZS_DUR_RST;
        end else if (wr_sel && ack_d) begin
            // mode 1 one-shot, mode 2 melody
            if (wb_sel_i[0]) begin
                sound_select_q.output_mode_field <= wb_dat_i[BZS_SEL_MODE_LSB +: 2];
            end
            if (wb_sel_i[1]) begin
                sound_select_q.duration_tempo_field <= wb_dat_i[BZS_SEL_DUR_LSB +: 4];
            end
        end
    end

    assign melody = (sound_select_q.output_mode_field == BZS_MODE_MELODY);
    assign mode_ok = melody
        | (sound_select_q.output_mode_field == BZS_MODE_ONESHOT);

    // ==========================================================
    // sound buffer
    // ==========================================================
    bzs_fifo #(
        .WIDTH(BZS_WORD_W),
        .DEPTH(BZS_FIFO_DEPTH)
    ) u_buffer (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push_want),
        .in_ready(fifo_in_ready),
        .in_data(wb_dat_i[BZS_WORD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign fifo_out_word = bzs_word_t'(fifo_out_data);

    // ==========================================================
    // sound clock enable
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (div_q == 11'(SND_DIV - 1)) begin
            div_q <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // sequencing
    // ==========================================================
    // note unit from tempo code; one-shot duration from the same field
    assign unit_lim = 14'(UNIT_BASE * (32'(sound_select_q.duration_tempo_field) + 1) - 1);
    assign dur_lim = 14'(DUR_BASE + DUR_STEP * 32'(sound_select_q.duration_tempo_field) - 1);

    // one-shot ends on duration; melody ends after length + 1 units
    always_comb begin
        end_now = 1'b0;
        if (state_q == BZS_PLAY && tick_q) begin
            if (melody) begin
                end_now = (sub_q == unit_lim) && (units_q == sound_reg_q.length_field);
            end else begin
                end_now = (sub_q == dur_lim);
            end
        end
    end

    assign load_now = (state_q == BZS_LOAD) && tick_q;
    assign next_note = end_now && melody && fifo_out_valid;
    assign finish = end_now && !next_note;
    assign fifo_out_ready = load_now | next_note;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= BZS_IDLE;
        end else begin
            case (state_q)
                BZS_IDLE: begin
                    if (fifo_out_valid && mode_ok) begin
                        state_q <= BZS_LOAD;
                    end
                end
                BZS_LOAD: begin
                    if (load_now) begin
                        state_q <= BZS_PLAY;
                    end
                end
                BZS_PLAY: begin
                    if (finish) begin
                        state_q <= BZS_IDLE;
                    end
                end
                default: begin
                    state_q <= BZS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sound_reg_q <= '0;
        end else if (fifo_out_ready) begin
            sound_reg_q <= fifo_out_word;
        end
    end

    // ==========================================================
    // note timing counters
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sub_q <= '0;
            units_q <= '0;
        end else if (fifo_out_ready) begin
            sub_q <= '0;
            units_q <= '0;
        end else if (state_q == BZS_PLAY && tick_q) begin
            if (melody && sub_q == unit_lim) begin
                sub_q <= '0;
                units_q <= units_q + 1'b1;
            end else begin
                sub_q <= sub_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // tone generation
    // ==========================================================
    // a tied word keeps the running phase so the two notes join
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tone_q <= '0;
        end else if (fifo_out_ready && !(next_note && fifo_out_word.tie_bit)) begin
            tone_q <= '0;
        end else if (state_q == BZS_PLAY && tick_q) begin
            if (tone_q >= sound_reg_q.frequency_field) begin
                tone_q <= '0;
            end else begin
                tone_q <= tone_q + 1'b1;
            end
        end
    end

    // one-shot: high for length + 1 of frequency + 1 ticks; melody: half period
    always_comb begin
        if (melody) begin
            tone_high = (tone_q <= {1'b0, sound_reg_q.frequency_field[7:1]});
        end else begin
            tone_high = (tone_q <= {2'b00, sound_reg_q.length_field});
        end
    end

    // short gap only before an untied note, so repeated notes stay audible
    assign mute = melody && !sound_reg_q.tie_bit && (units_q == '0)
        && (sub_q < 14'(BZS_BREAK_TICKS));
    assign buzzer_d = (state_q == BZS_PLAY) && tone_high && !mute
        && !(melody && sound_reg_q.note_rest_bit);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            buzzer_q <= 1'b0;
        end else begin
            buzzer_q <= buzzer_d;
        end
    end

    assign buzzer_o = buzzer_q;

    // ==========================================================
    // flags
    // ==========================================================
    // hardware set beats a same-cycle clear on every flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            buffer_empty_q <= 1'b1;
        end else if (fifo_out_ready) begin
            buffer_empty_q <= 1'b1;
        end else if (push_want && fifo_in_ready) begin
            buffer_empty_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_busy_q <= 1'b0;
        end else if (fifo_out_ready) begin
            output_busy_q <= 1'b1;
        end else if (finish) begin
            output_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_done_q <= 1'b0;
        end else if (finish) begin
            output_done_q <= 1'b1;
        end else if ((push_want && fifo_in_ready)
                || (wr_flags && wb_dat_i[BZS_FLG_DONE])) begin
            output_done_q <= 1'b0;
        end
    end

endmodule

// ### bzs_checker.sv
// bzs_checker: bus and tone timing properties of the sound sequencer ports
`timescale 1ns/1ns
module bzs_checker
    import bzs_pkg::*;
#(
    parameter int unsigned SND_DIV = BZS_SND_DIV_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic buzzer_o
);
    // ==========================================================
    // properties
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;

    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
    property p_ack_cause;
        wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_read_ack; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_read_ack: assert property (p_read_ack) else $error("read not acked next cycle");
    property p_reg_wr_ack;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:2] != 6'h01 |=> wb_ack_o;
    endproperty
    a_reg_wr_ack: assert property (p_reg_wr_ack) else $error("write not acked");
    property p_unmapped; rd_ack && wb_adr_i[7:2] > 6'h02 |-> wb_dat_o == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_flag_bits; rd_ack && wb_adr_i[7:2] == 6'h02 |-> wb_dat_o[31:3] == 29'h0; endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("flag spare bits set");
    property p_sel_bits;
        rd_ack && wb_adr_i[7:2] == 6'h00 |-> wb_dat_o[31:12] == 20'h0 && wb_dat_o[7:2] == 6'h0;
    endproperty
    a_sel_bits: assert property (p_sel_bits) else $error("select spare bits set");
    property p_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without ack");
    // a tone level lasts at least one sound tick, four clocks on the bench
    property p_tone_step; $changed(buzzer_o) |=> $stable(buzzer_o) [*3]; endproperty
    a_tone_step: assert property (p_tone_step) else $error("tone edge inside a tick");
    property p_silent_done;
        rd_ack && wb_adr_i[7:2] == 6'h02 && wb_dat_o[2] && !wb_dat_o[1] |-> !buzzer_o;
    endproperty
    a_silent_done: assert property (p_silent_done) else $error("tone after done");

    c_stall: cover property ((wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) [*3]);
    c_done: cover property (rd_ack && wb_adr_i[7:2] == 6'h02 && wb_dat_o[2]);
    c_tone: cover property ($rose(buzzer_o));
endmodule

bind bzs_sequencer bzs_checker #(.SND_DIV(SND_DIV)) u_bzs_checker (
    .clk(clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .buzzer_o(buzzer_o)
);

// ### bzs_buzzer_model.sv
// bzs_buzzer_model: piezo load on the buzzer pin, counts membrane strikes
`timescale 1ns/1ns
module bzs_buzzer_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic drive,
    input wire logic clr,
    output logic [15:0] edge_cnt
);
    // ==========================================================
    // strike counter
    // ==========================================================
    logic drive_q;
    // a strike is a rising drive level; pure load, never drives back
    always_ff @(posedge clk) begin
        if (!rst_b || clr) begin
            edge_cnt <= 16'h0000;
            drive_q <= 1'b0;
        end else begin
            drive_q <= drive;
            if (drive && !drive_q) begin
                edge_cnt <= edge_cnt + 16'h0001;
            end
        end
    end
endmodule

// ### test_buzzer_oneshot_melody_sequencer.sv
// test_buzzer_oneshot_melody_sequencer: register level bench of the sound sequencer
`timescale 1ns/1ns
module test_buzzer_oneshot_melody_sequencer
    import bzs_pkg::*;
;
    // ==========================================================
    // signals and instances
    // ==========================================================
    logic clk, rst_b, cyc, stb, we, clr, wb_ack_o, buzzer_o;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, wb_dat_o, rdat;
    logic [15:0] edge_cnt;
    int fails = 0;
    int n_tests = 0;
    int wait_n = 0;
    int cycles = 0;

    // short sound tick and counts keep the run small
    bzs_sequencer #(.SND_DIV(4), .DUR_BASE(3), .DUR_STEP(2), .UNIT_BASE(2)) dut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .buzzer_o(buzzer_o)
    );
    bzs_buzzer_model u_load (.clk(clk), .rst_b(rst_b), .drive(buzzer_o), .clr(clr),
        .edge_cnt(edge_cnt));

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic complete_run;
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle; ack and read data are taken at the rising edge that samples ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        wait_n = 0;
        do begin
            @(posedge clk);
            wait_n++;
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic clr_load;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    // software side waits on the flags, as a driver polling would
    task automatic poll_done;
        do begin
            bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        end while (rdat[2] !== 1'b1);
    endtask

    // ==========================================================
    // clock, timeout and sequence
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        rst_b = 1'b0;
        {cyc, stb, we, clr} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, 8'h00, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0000);
        bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0001);
        bus(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
        bus(1'b0, 8'h10, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
        bus(1'b0, 8'h00, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0f03);
        // one-shot: word parked in mode 0, then released by the mode write
        bus(1'b1, 8'h00, 32'h0000_0100, 4'hf);
        bus(1'b1, 8'h04, 32'h0000_0103, 4'hf);
        bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0000);
        clr_load();
        bus(1'b1, 8'h00, 32'h0000_0101, 4'hf);
        poll_done();
        check(rdat, 32'h0000_0005);
        bus(1'b0, 8'h04, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0103);
        check({16'h0000, edge_cnt}, 32'h0000_0002);
        // melody: a half note then a half rest, period four ticks
        bus(1'b1, 8'h00, 32'h0000_0000, 4'hf);
        bus(1'b1, 8'h04, 32'h0000_0f03, 4'hf);
        bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_4f03, 4'hf);
        clr_load();
        bus(1'b1, 8'h00, 32'h0000_0002, 4'hf);
        poll_done();
        check(rdat, 32'h0000_0005);
        // 32 ticks at period 4, first unit muted: seven of eight periods strike
        check({16'h0000, edge_cnt}, 32'h0000_0007);
        bus(1'b0, 8'h04, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_4f03);
        bus(1'b1, 8'h08, 32'h0000_0004, 4'hf);
        bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0001);
        // buffer filled with short rests until a write stalls
        bus(1'b1, 8'h00, 32'h0000_0000, 4'hf);
        repeat (8) bus(1'b1, 8'h04, 32'h0000_4003, 4'hf);
        clr_load();
        bus(1'b1, 8'h00, 32'h0000_0002, 4'hf);
        // seven words queue behind the one playing, so the third write must wait
        repeat (3) bus(1'b1, 8'h04, 32'h0000_4003, 4'hf);
        check(32'(wait_n > 2), 32'h0000_0001);
        poll_done();
        check(rdat, 32'h0000_0005);
        check({16'h0000, edge_cnt}, 32'h0000_0000);
        // a one-lane buffer write is dropped and leaves done set
        bus(1'b1, 8'h04, 32'h0000_0103, 4'h1);
        bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
        check(rdat, 32'h0000_0005);
        complete_run();
    end
endmodule
